// ---- cmx_feeder.sv ----
`timescale 1ns/1ps
module cmx_feeder (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // block side
    input wire logic in_ready_out,
    input wire logic [2:0] in_subch_out,
    output logic in_bit_in,
    output logic in_valid_in
);
    logic [9:0] cnt [8];
    logic pause;

    function automatic logic pat(input logic [2:0] s, input logic [9:0] k);
        return k[0] ^ k[3] ^ k[7] ^ s[0] ^ s[1];
    endfunction

    // counts never wrap: good for one frame only
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int s = 0; s < 8; s++) begin
                cnt[s] <= 10'h000;
            end
            pause <= 1'b0;
        end else if (in_valid_in && in_ready_out) begin
            cnt[in_subch_out] <= cnt[in_subch_out] + 10'h001;
            pause <= cnt[in_subch_out][1:0] == 2'h3;
        end else begin
            pause <= 1'b0;
        end
    end

    // idle after every fourth bit, showing the inverse so stale data never matches
    assign in_valid_in = !pause;
    assign in_bit_in = pat(in_subch_out, cnt[in_subch_out]) ^ pause;
endmodule

// ---- cmx_fifo.sv ----
`timescale 1ns/1ps
module cmx_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [$clog2(DEPTH):0] level_out
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("cmx_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic push;
    logic pop;
    logic [AW:0] next_level;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

    always_comb begin
        next_level = level_out;
        if (push && !pop) begin
            next_level = level_out + 1'b1;
        end else if (pop && !push) begin
            next_level = level_out - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
        // bypass keeps the head register right when a word lands in an empty store
        if (push && wr_ptr == next_rd_ptr) begin
            out_data_out <= in_data_in;
        end else begin
            out_data_out <= mem[next_rd_ptr];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level_out <= '0;
            in_ready_out <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            level_out <= next_level;
            in_ready_out <= next_level != (AW+1)'(DEPTH);
            out_valid_out <= next_level != '0;
        end
    end
endmodule

// ---- cmx_frame_mux.sv ----
`timescale 1ns/1ps
module cmx_frame_mux
    import cmx_pkg::*;
#(
    parameter int NUM_SUBCH = 8,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // sub-channel layout
    input wire logic cfg_we_in,
    input wire logic [$clog2(NUM_SUBCH)-1:0] cfg_sel_in,
    input wire logic cfg_enable_in,
    input wire logic [9:0] cfg_start_in,
    input wire logic [9:0] cfg_size_in,
    // interleaved sub-channel bits
    input wire logic in_bit_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [$clog2(NUM_SUBCH)-1:0] in_subch_out,
    // assembled frame bits
    output logic out_bit_out,
    output logic out_first_out,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [12:0] cif_count_out,
    // transmission frame timing
    output logic frame_start_out,
    output logic symbol_start_out,
    output logic guard_end_out,
    output logic null_blank_out,
    output logic guard_active_out,
    output logic phase_ref_out,
    output logic [6:0] symbol_index_out,
    // carrier sweep
    output logic carrier_req_out,
    output logic [10:0] carrier_idx_out,
    output logic carrier_zero_out
);
    localparam int SW = $clog2(NUM_SUBCH);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    if (NUM_SUBCH < 2 || FIFO_DEPTH < 2) begin
        $error("cmx_frame_mux: NUM_SUBCH and FIFO_DEPTH must be >= 2");
    end
    if (int'(CMX_NULL_LEN) + int'(CMX_SYM_LAST) * int'(CMX_SYM_LEN) != CMX_FRAME_LEN) begin
        $error("cmx_frame_mux: symbol lengths do not fill the frame");
    end

    // layout table
    logic [NUM_SUBCH-1:0] cfg_en;
    logic [9:0] cfg_start [NUM_SUBCH];
    logic [9:0] cfg_size [NUM_SUBCH];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_en <= '0;
        end else if (cfg_we_in) begin
            cfg_en[cfg_sel_in] <= cfg_enable_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (cfg_we_in) begin
            cfg_start[cfg_sel_in] <= cfg_start_in;
            cfg_size[cfg_sel_in] <= cfg_size_in;
        end
    end

    // assembly walk
    logic [15:0] bit_idx;
    logic [15:0] next_bit_idx;
    logic primed;
    logic owned;
    logic take;
    logic pad_step;
    logic step;
    logic fifo_in_ready;
    logic [LW-1:0] fifo_level;
    logic [LW-1:0] next_fifo_level;
    logic [NUM_SUBCH-1:0] hit;
    logic hit_any;
    logic [SW-1:0] hit_sel;
    logic prbs_bit;
    logic [8:0] prbs_state;
    logic [1:0] push_data;
    logic [1:0] fifo_out;

    assign take = in_ready_out && in_valid_in;
    assign pad_step = primed && !owned && fifo_in_ready;
    assign step = take || pad_step;
    assign push_data = {bit_idx == '0, owned ? in_bit_in : prbs_bit};

    always_comb begin
        next_bit_idx = bit_idx;
        if (step) begin
            next_bit_idx = (bit_idx == CMX_BIT_LAST) ? '0 : bit_idx + 16'h0001;
        end
    end

    // a unit belongs to a sub-channel inside [start, start + size)
    genvar g;
    generate
        for (g = 0; g < NUM_SUBCH; g++) begin : g_hit
            assign hit[g] = cfg_en[g]
                && ({1'b0, next_bit_idx[15:CMX_CU_SHIFT]} >= {1'b0, cfg_start[g]})
                && ({1'b0, next_bit_idx[15:CMX_CU_SHIFT]}
                    < {1'b0, cfg_start[g]} + {1'b0, cfg_size[g]});
        end
    endgenerate

    // overlapping entries resolve to the lowest index
    always_comb begin
        hit_any = 1'b0;
        hit_sel = '0;
        for (int i = NUM_SUBCH - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_any = 1'b1;
                hit_sel = SW'(i);
            end
        end
    end

    always_comb begin
        next_fifo_level = fifo_level;
        if (step && !(out_valid_out && out_ready_in)) begin
            next_fifo_level = fifo_level + 1'b1;
        end else if (!step && out_valid_out && out_ready_in) begin
            next_fifo_level = fifo_level - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_idx <= '0;
            primed <= 1'b0;
            owned <= 1'b0;
            in_subch_out <= '0;
            in_ready_out <= 1'b0;
        end else begin
            bit_idx <= next_bit_idx;
            primed <= 1'b1;
            owned <= hit_any;
            in_subch_out <= hit_sel;
            // ready promises a free slot even if nothing drains meanwhile
            in_ready_out <= hit_any && (next_fifo_level != LW'(FIFO_DEPTH));
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cif_count_out <= '0;
        end else if (step && bit_idx == CMX_BIT_LAST) begin
            cif_count_out <= (cif_count_out == CMX_CIF_COUNT_LAST) ? '0
                : cif_count_out + 13'h0001;
        end
    end

    cmx_prbs u_prbs (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .restart_in(step && bit_idx == CMX_BIT_LAST),
        .advance_in(step),
        .bit_out(prbs_bit),
        .state_out(prbs_state)
    );

    cmx_fifo #(
        .WIDTH(2),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .in_data_in(push_data),
        .in_valid_in(step),
        .in_ready_out(fifo_in_ready),
        .out_data_out(fifo_out),
        .out_valid_out(out_valid_out),
        .out_ready_in(out_ready_in),
        .level_out(fifo_level)
    );

    assign out_bit_out = fifo_out[0];
    assign out_first_out = fifo_out[1];

    // elementary period tick from a fractional accumulator
    logic [28:0] acc;
    logic [28:0] acc_sum;
    logic tick;
    logic [11:0] period_cnt;
    logic [6:0] sym_idx;
    logic [11:0] sym_len;
    logic sym_wrap;
    logic [11:0] next_period_cnt;
    logic [6:0] next_sym_idx;

    assign acc_sum = acc + CMX_ACC_STEP;
    assign tick = acc_sum >= CMX_ACC_WRAP;
    assign sym_len = (sym_idx == '0) ? CMX_NULL_LEN : CMX_SYM_LEN;
    assign sym_wrap = tick && period_cnt == sym_len - 12'h001;
    assign next_period_cnt = sym_wrap ? 12'h000 : period_cnt + {11'h000, tick};
    assign next_sym_idx = !sym_wrap ? sym_idx
        : (sym_idx == CMX_SYM_LAST) ? '0 : sym_idx + 7'h01;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc <= '0;
        end else begin
            acc <= tick ? acc_sum - CMX_ACC_WRAP : acc_sum;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            period_cnt <= '0;
            sym_idx <= '0;
        end else begin
            period_cnt <= next_period_cnt;
            sym_idx <= next_sym_idx;
        end
    end

    // strobes mark the clock on which the counter enters the new period
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_start_out <= 1'b0;
            symbol_start_out <= 1'b0;
            guard_end_out <= 1'b0;
            null_blank_out <= 1'b1;
            guard_active_out <= 1'b0;
            phase_ref_out <= 1'b0;
            symbol_index_out <= '0;
        end else begin
            frame_start_out <= sym_wrap && sym_idx == CMX_SYM_LAST;
            symbol_start_out <= sym_wrap && sym_idx != CMX_SYM_LAST;
            guard_end_out <= tick && sym_idx != '0
                && period_cnt == CMX_GUARD_LEN - 12'h001;
            null_blank_out <= next_sym_idx == '0;
            guard_active_out <= next_sym_idx != '0 && next_period_cnt < CMX_GUARD_LEN;
            phase_ref_out <= next_sym_idx == 7'h01;
            symbol_index_out <= next_sym_idx;
        end
    end

    // carrier sweep, one request per clock after each symbol start
    cmx_cg_state_type cg_state;
    logic [10:0] car_cnt;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cg_state <= CMX_CG_IDLE;
            car_cnt <= '0;
            carrier_req_out <= 1'b0;
            carrier_idx_out <= '0;
            carrier_zero_out <= 1'b0;
        end else begin
            carrier_req_out <= 1'b0;
            carrier_zero_out <= 1'b0;
            case (cg_state)
                CMX_CG_IDLE: begin
                    car_cnt <= '0;
                    if (symbol_start_out) begin
                        cg_state <= CMX_CG_RUN;
                    end
                end
                CMX_CG_RUN: begin
                    carrier_req_out <= 1'b1;
                    carrier_idx_out <= car_cnt - CMX_CAR_HALF;
                    carrier_zero_out <= car_cnt == CMX_CAR_HALF;
                    car_cnt <= car_cnt + 11'h001;
                    if (car_cnt == CMX_CAR_LAST) begin
                        cg_state <= CMX_CG_IDLE;
                    end
                end
                default: begin
                    cg_state <= CMX_CG_IDLE;
                end
            endcase
        end
    end

    AST_PAD_PRBS: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        pad_step |-> push_data[0] == prbs_bit)
        else $error("padding bit differs from sequence");
    AST_PRBS_RESTART: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        step && bit_idx == CMX_BIT_LAST |=> prbs_state == CMX_PRBS_SEED && bit_idx == '0)
        else $error("sequence not restarted at frame bit zero");
    AST_BIT_RANGE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        bit_idx <= CMX_BIT_LAST)
        else $error("frame bit index out of range");
    AST_TAKE_OWNED: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        take |-> owned && !pad_step && fifo_in_ready)
        else $error("input taken outside an occupied unit");
    AST_CIF_WRAP: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        step && bit_idx == CMX_BIT_LAST && cif_count_out == CMX_CIF_COUNT_LAST
        |=> cif_count_out == '0)
        else $error("frame count does not wrap at 5000");
    AST_NULL_TO_SYM1: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        sym_wrap && sym_idx == '0 && period_cnt == CMX_NULL_LEN - 12'h001
        |=> symbol_start_out && !null_blank_out ##1 phase_ref_out)
        else $error("null symbol length wrong");
    AST_FRAME_END: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        tick && sym_idx == CMX_SYM_LAST && period_cnt == CMX_SYM_LEN - 12'h001
        |=> frame_start_out ##1 null_blank_out)
        else $error("frame does not close after the last symbol");
    AST_GUARD_END: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        guard_end_out |-> period_cnt == CMX_GUARD_LEN && sym_idx != '0 ##1 !guard_active_out)
        else $error("guard end misplaced");
    AST_CAR_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        carrier_req_out && carrier_idx_out == '0 |-> carrier_zero_out)
        else $error("centre carrier not forced to zero");
    AST_NULL_BLANK: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        frame_start_out |-> null_blank_out && !carrier_req_out)
        else $error("output not blanked in null symbol");
endmodule

// ---- cmx_frame_mux_tb.sv ----
`timescale 1ns/1ps
module cmx_frame_mux_tb;
    import cmx_pkg::*;
    logic sys_clk_in, rstn_in, cfg_we_in, cfg_enable_in, in_bit_in, in_valid_in;
    logic in_ready_out, out_bit_out, out_first_out, out_valid_out, out_ready_in;
    logic frame_start_out, symbol_start_out, guard_end_out, null_blank_out;
    logic guard_active_out, phase_ref_out, carrier_req_out, carrier_zero_out;
    logic [2:0] cfg_sel_in, in_subch_out;
    logic [9:0] cfg_start_in, cfg_size_in;
    logic [12:0] cif_count_out;
    logic [6:0] symbol_index_out;
    logic [10:0] carrier_idx_out;
    int bad_count = 0;
    int n_compared = 0;
    int pulses = 0;
    // back-to-back pair, then a run ending on the last unit
    logic [9:0] lay_start [3] = '{10'h002, 10'h005, 10'h35C};
    logic [9:0] lay_size [3] = '{10'h003, 10'h001, 10'h004};

    cmx_frame_mux #(.NUM_SUBCH(8), .FIFO_DEPTH(8)) dut (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
        .cfg_we_in(cfg_we_in), .cfg_sel_in(cfg_sel_in), .cfg_enable_in(cfg_enable_in),
        .cfg_start_in(cfg_start_in), .cfg_size_in(cfg_size_in),
        .in_bit_in(in_bit_in), .in_valid_in(in_valid_in), .in_ready_out(in_ready_out),
        .in_subch_out(in_subch_out), .out_bit_out(out_bit_out),
        .out_first_out(out_first_out), .out_valid_out(out_valid_out),
        .out_ready_in(out_ready_in), .cif_count_out(cif_count_out),
        .frame_start_out(frame_start_out), .symbol_start_out(symbol_start_out),
        .guard_end_out(guard_end_out), .null_blank_out(null_blank_out),
        .guard_active_out(guard_active_out), .phase_ref_out(phase_ref_out),
        .symbol_index_out(symbol_index_out), .carrier_req_out(carrier_req_out),
        .carrier_idx_out(carrier_idx_out), .carrier_zero_out(carrier_zero_out)
    );

    cmx_feeder u_feed (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .in_ready_out(in_ready_out),
        .in_subch_out(in_subch_out), .in_bit_in(in_bit_in), .in_valid_in(in_valid_in)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    // the whole run stays inside the first null symbol
    always @(posedge sys_clk_in) begin
        if (rstn_in && {frame_start_out, symbol_start_out, guard_end_out, carrier_req_out,
                guard_active_out, phase_ref_out, null_blank_out} !== 7'h01) begin
            pulses <= pulses + 1;
        end
    end

    function automatic logic pat(input logic [2:0] s, input logic [9:0] k);
        return k[0] ^ k[3] ^ k[7] ^ s[0] ^ s[1];
    endfunction

    function automatic int owner(input int u);
        for (int s = 0; s < 3; s++) begin
            if (u >= lay_start[s] && u < lay_start[s] + lay_size[s]) begin
                return s;
            end
        end
        return 3;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic test_reset();
        check(in_ready_out, 1'b0);
        check(out_valid_out, 1'b0);
        check(null_blank_out, 1'b1);
        check(cif_count_out, 13'h0000);
        check(symbol_index_out, 7'h00);
        $display("test_reset done");
    endtask

    task automatic test_layout();
        for (int s = 0; s < 8; s++) begin
            @(posedge sys_clk_in);
            cfg_we_in <= 1'b1;
            cfg_sel_in <= 3'(s);
            cfg_enable_in <= s < 3;
            cfg_start_in <= s < 3 ? lay_start[s % 3] : 10'h000;
            cfg_size_in <= s < 3 ? lay_size[s % 3] : 10'h000;
        end
        @(posedge sys_clk_in);
        cfg_we_in <= 1'b0;
        $display("test_layout done");
    endtask

    // drain one frame plus the next first bit, with a long stall in sub-channel 0
    task automatic test_frame();
        logic [8:0] prbs;
        logic want;
        int i;
        int s;
        int cyc;
        int hold;
        prbs = 9'h1FF;
        i = 0;
        cyc = 0;
        hold = 0;
        while (i < 55297) begin
            @(posedge sys_clk_in);
            cyc++;
            if (cyc > 90000) begin
                bad_count++;
                $display("[ERR] t=%0t seen=%0h want=%0h", $time, i, 55297);
                break;
            end
            if (out_valid_out === 1'b1 && out_ready_in === 1'b1) begin
                if (i == 55296) begin
                    prbs = 9'h1FF;
                    check(cif_count_out, 13'h0001);
                end
                s = owner((i % 55296) / 64);
                want = prbs[8] ^ prbs[4];
                prbs = {prbs[7:0], want};
                if (s < 3) begin
                    want = pat(3'(s), 10'(i - lay_start[s] * 64));
                end
                check(out_bit_out, want);
                check(out_first_out, i % 55296 == 0);
                i++;
            end
            if (i >= 160 && hold < 40) begin
                out_ready_in <= 1'b0;
                hold++;
                if (hold == 40) begin
                    check(in_ready_out, 1'b0);
                    check(in_subch_out, 3'h0);
                    check(out_valid_out, 1'b1);
                end
            end else begin
                out_ready_in <= (cyc % 7) != 6;
            end
        end
        out_ready_in <= 1'b0;
        $display("test_frame done");
    endtask

    task automatic test_timing();
        check(pulses, 0);
        check(carrier_idx_out, 11'h000);
        check(carrier_zero_out, 1'b0);
        check(null_blank_out, 1'b1);
        check(symbol_index_out, 7'h00);
        $display("test_timing done");
    endtask

    initial begin
        rstn_in = 1'b0;
        cfg_we_in = 1'b0;
        cfg_sel_in = 3'h0;
        cfg_enable_in = 1'b0;
        cfg_start_in = 10'h000;
        cfg_size_in = 10'h000;
        out_ready_in = 1'b0;
        repeat (8) @(posedge sys_clk_in);
        test_reset();
        rstn_in <= 1'b1;
        test_layout();
        test_frame();
        test_timing();
        end_sim();
    end
endmodule

// ---- cmx_pkg.sv ----
package cmx_pkg;
    // elementary period rate and system clock, both in hertz
    localparam int CMX_CLK_HZ = 200_000_000;
    localparam int CMX_ELEM_HZ = 2_048_000;
    localparam logic [28:0] CMX_ACC_STEP = 29'(CMX_ELEM_HZ);
    localparam logic [28:0] CMX_ACC_WRAP = 29'(CMX_CLK_HZ);
    // frame layout in bits and capacity units
    localparam logic [15:0] CMX_BIT_LAST = 16'hD7FF;
    localparam logic [9:0] CMX_CU_LAST = 10'h35F;
    localparam int CMX_CU_SHIFT = 6;
    localparam logic [12:0] CMX_CIF_COUNT_LAST = 13'h1387;
    // symbol timing in elementary periods
    localparam logic [11:0] CMX_NULL_LEN = 12'hA60;
    localparam logic [11:0] CMX_SYM_LEN = 12'h9F8;
    localparam logic [11:0] CMX_GUARD_LEN = 12'h1F8;
    localparam logic [11:0] CMX_USEFUL_LEN = 12'h800;
    localparam logic [6:0] CMX_SYM_LAST = 7'h4C;
    localparam int CMX_FRAME_LEN = 196_608;
    // carrier sweep: index 0 .. 1536 mapped to k = -768 .. 768
    localparam logic [10:0] CMX_CAR_LAST = 11'h600;
    localparam logic [10:0] CMX_CAR_HALF = 11'h300;
    localparam logic [8:0] CMX_PRBS_SEED = 9'h1FF;

    typedef enum logic {CMX_CG_IDLE, CMX_CG_RUN} cmx_cg_state_type;
endpackage

// ---- cmx_prbs.sv ----
`timescale 1ns/1ps
module cmx_prbs
    import cmx_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic restart_in,
    input wire logic advance_in,
    output logic bit_out,
    output logic [8:0] state_out
);
    // x^9 + x^5 + 1, loaded with all ones
    assign bit_out = state_out[8] ^ state_out[4];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_out <= CMX_PRBS_SEED;
        end else if (restart_in) begin
            state_out <= CMX_PRBS_SEED;
        end else if (advance_in) begin
            state_out <= {state_out[7:0], bit_out};
        end
    end
endmodule
